// [include/slot_cfg_regs.vh]
// register offsets, field positions, reset values and limits for the serial port slot configuration block
// Operation
// - standby port occupies no WAN slots
// - control leads follow port condition
// - any slot subset, non-adjacent allowed
// - slots 1-24 on T1, 1-31 on E1
// - no E1 slot 16 under CAS/CCS
// - one per-slot rate, speed rate times slots
// - oversize destination port becomes port 1
// - interface role DCE or DTE
// - save commits staged settings
// - undo restores last saved settings
// - copy duplicates selected port to next
`ifndef SLOT_CFG_REGS_VH
`define SLOT_CFG_REGS_VH

// register byte offsets
`define OFS_PORT_SEL 12'h000
`define OFS_CFG 12'h004
`define OFS_SLOT_MAP 12'h008
`define OFS_ACTION 12'h00c
`define OFS_STATUS 12'h010
`define OFS_ACT_MAP 12'h014
`define OFS_ACT_CFG 12'h018
`define OFS_SPEED 12'h01c

// config word fields
`define CFG_ACTIVE 0
`define CFG_DTE 1
`define CFG_RATE64 2
`define CFG_E1 3
`define CFG_SIG 4
`define CFG_CTS_LO 5
`define CFG_CTS_HI 6
`define CFG_RLSD_RTS 7
`define CFG_DEST_LO 8
`define CFG_DEST_HI 9
`define CFG_DPORT_LO 12
`define CFG_DPORT_HI 15
`define CFG_WIDTH 16

// action bits
`define ACT_SAVE 0
`define ACT_UNDO 1
`define ACT_COPY 2

// reset values: standby, dce, 56k, T1, cts perm
`define CFG_RESET 16'h0000
`define MAP_RESET 32'h0000_0000

// slot limits
`define T1_SLOTS 24
`define E1_SLOTS 31
`define E1_SIG_SLOT 16

// cts modes
`define CTS_PERM 2'h0
`define CTS_RLOCAL 2'h1
`define CTS_IGNOR 2'h2
`define CTS_LOCAL 2'h3

// destination kinds
`define DEST_USER 2'h2

// per-slot rates in kbps
`define RATE_56K 11'd56
`define RATE_64K 11'd64
`endif

// [verilog/slot_cfg.v]
// per-port slot, role, lead and staging configuration with an APB register slave
`include "slot_cfg_regs.vh"

module slot_cfg #(
	parameter NPORTS = 4,
	parameter PW = 2,
	parameter DEST_PORTS = 4
) (
	// clock and reset
	input wire clk_sys,
	input wire sys_rst,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// data path view of port 0 .. NPORTS-1 selected by mon_port
	input wire [PW-1:0] mon_port,
	input wire link_down,
	input wire local_rts,
	input wire remote_rts,
	output reg rlsd_ff,
	output reg dsr_ff,
	output reg cts_ff,
	output reg dte_role_ff,
	output reg [31:0] wan_slots_ff,
	output reg [10:0] port_kbps_ff
);

	reg [`CFG_WIDTH-1:0] stg_cfg [0:NPORTS-1];
	reg [`CFG_WIDTH-1:0] act_cfg [0:NPORTS-1];
	reg [31:0] stg_map [0:NPORTS-1];
	reg [31:0] act_map [0:NPORTS-1];
	reg [PW-1:0] sel_ff;
	reg refused_ff;

	// synchroniser stages: bit 0 local rts, bit 1 remote rts, bit 2 link down
	reg [2:0] rts_s1_ff;
	reg [2:0] rts_s2_ff;
	reg [2:0] rts_s3_ff;

	// filtered pin levels, only changed once two stages agree
	reg lrts_ff;
	reg rrts_ff;
	reg ldown_ff;

	// next values of the apb outputs
	reg nxt_pready;
	reg nxt_pslverr;
	reg [31:0] nxt_prdata;

	// next values of the lead and data-path outputs
	reg nxt_rlsd;
	reg nxt_dsr;
	reg nxt_lead_cts;
	reg [31:0] nxt_slots;
	reg [10:0] nxt_kbps;

	// loop index for the per-port arrays
	integer i;

	// filtered link state as seen by software
	wire link_down_seen = ldown_ff;

	// legal slot mask for a link type and signalling
	function [31:0] slot_mask;
		input e1;
		input sig;
		begin
			slot_mask = e1 ? 32'hffff_fffe : 32'h01ff_fffe;
			if (e1 && sig)
				slot_mask[`E1_SIG_SLOT] = 1'b0;
		end
	endfunction

	// number of set bits in a slot map
	function [5:0] slot_count;
		input [31:0] m;
		integer k;
		begin
			slot_count = 6'h00;
			for (k = 0; k < 32; k = k + 1)
				slot_count = slot_count + {5'h00, m[k]};
		end
	endfunction

	// clamp a user destination port to those that exist
	function [15:0] fix_dest;
		input [15:0] c;
		reg [3:0] p;
		begin
			p = c[`CFG_DPORT_HI:`CFG_DPORT_LO];
			fix_dest = c;
			if (c[`CFG_DEST_HI:`CFG_DEST_LO] == `DEST_USER &&
				(p == 4'h0 || {28'h000_0000, p} > DEST_PORTS))
				fix_dest[`CFG_DPORT_HI:`CFG_DPORT_LO] = 4'h1;
		end
	endfunction

	// aggregate speed for a committed port
	// a standby port reports zero so the speed never counts unused slots
	function [10:0] speed_of;
		input [15:0] c;
		input [31:0] m;
		reg [10:0] r;
		begin
			r = c[`CFG_RATE64] ? `RATE_64K : `RATE_56K;
			speed_of = c[`CFG_ACTIVE] ? r * {5'h00, slot_count(m)} : 11'h000;
		end
	endfunction

	// bus phase decode
	wire wr = psel && penable && pwrite;
	wire rd = psel && penable && !pwrite;
	wire [PW-1:0] nxt_port = sel_ff + {{(PW-1){1'b0}}, 1'b1};
	wire [`CFG_WIDTH-1:0] cur_cfg = stg_cfg[sel_ff];
	wire [31:0] wmask = slot_mask(cur_cfg[`CFG_E1], cur_cfg[`CFG_SIG]);

	// ready one cycle after setup; error for offsets past the last register
	always @* begin
		nxt_pready = psel && !penable;
		nxt_pslverr = psel && !penable && (paddr > `OFS_SPEED);
	end

	// apb register writes, staging and actions; single-cycle access
	// edits land only in the staged arrays so the data path never sees half a setup
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sel_ff <= {PW{1'b0}};
			refused_ff <= 1'b0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			for (i = 0; i < NPORTS; i = i + 1) begin
				stg_cfg[i] <= `CFG_RESET;
				act_cfg[i] <= `CFG_RESET;
				stg_map[i] <= `MAP_RESET;
				act_map[i] <= `MAP_RESET;
			end
		end else begin
			pready <= nxt_pready;
			pslverr <= nxt_pslverr;
			if (wr && pready) begin
				case (paddr)
				`OFS_PORT_SEL: sel_ff <= pwdata[PW-1:0];
				`OFS_CFG: begin
					stg_cfg[sel_ff] <= fix_dest(pwdata[15:0]);
					// narrowing to E1 sig drops slot 16
					stg_map[sel_ff] <= stg_map[sel_ff] & slot_mask(pwdata[`CFG_E1], pwdata[`CFG_SIG]);
				end
				`OFS_SLOT_MAP: begin
					stg_map[sel_ff] <= pwdata & wmask;
					refused_ff <= |(pwdata & ~wmask);
				end
				`OFS_ACTION: begin
					if (pwdata[`ACT_SAVE]) begin
						for (i = 0; i < NPORTS; i = i + 1) begin
							act_cfg[i] <= stg_cfg[i];
							act_map[i] <= stg_map[i];
						end
					end else if (pwdata[`ACT_UNDO]) begin
						for (i = 0; i < NPORTS; i = i + 1) begin
							stg_cfg[i] <= act_cfg[i];
							stg_map[i] <= act_map[i];
						end
					end else if (pwdata[`ACT_COPY]) begin
						stg_cfg[nxt_port] <= stg_cfg[sel_ff];
						stg_map[nxt_port] <= stg_map[sel_ff];
					end
				end
				default: ;
				endcase
			end
		end
	end

	// read data of the addressed register
	always @* begin
		case (paddr)
		`OFS_PORT_SEL: nxt_prdata = {{(32-PW){1'b0}}, sel_ff};
		`OFS_CFG: nxt_prdata = {16'h0000, stg_cfg[sel_ff]};
		`OFS_SLOT_MAP: nxt_prdata = stg_map[sel_ff];
		`OFS_STATUS: nxt_prdata = {30'h0, link_down_seen, refused_ff};
		`OFS_ACT_MAP: nxt_prdata = act_map[sel_ff];
		`OFS_ACT_CFG: nxt_prdata = {16'h0000, act_cfg[sel_ff]};
		`OFS_SPEED: nxt_prdata = {21'h0, speed_of(act_cfg[sel_ff], act_map[sel_ff])};
		default: nxt_prdata = 32'h0000_0000;
		endcase
	end

	// apb read data, captured in the setup cycle
	// held until the next setup so a slow master still sees stable data
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= nxt_prdata;
		end
	end

	// three-stage synchronisers; change taken when stages two and three agree
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rts_s1_ff <= 3'h0;
			rts_s2_ff <= 3'h0;
			rts_s3_ff <= 3'h0;
			lrts_ff <= 1'b0;
			rrts_ff <= 1'b0;
			ldown_ff <= 1'b0;
		end else begin
			rts_s1_ff <= {link_down, remote_rts, local_rts};
			rts_s2_ff <= rts_s1_ff;
			rts_s3_ff <= rts_s2_ff;
			if (rts_s2_ff[0] == rts_s3_ff[0])
				lrts_ff <= rts_s3_ff[0];
			if (rts_s2_ff[1] == rts_s3_ff[1])
				rrts_ff <= rts_s3_ff[1];
			if (rts_s2_ff[2] == rts_s3_ff[2])
				ldown_ff <= rts_s3_ff[2];
		end
	end

	wire [15:0] mc = act_cfg[mon_port];
	reg nxt_cts;

	// cts by configured mode
	always @* begin
		case (mc[`CFG_CTS_HI:`CFG_CTS_LO])
		`CTS_PERM: nxt_cts = 1'b1;
		`CTS_IGNOR: nxt_cts = 1'b0;
		default: nxt_cts = lrts_ff;
		endcase
	end

	// lead levels and slots of the monitored port by its condition
	// only the committed copy is used, so pending edits never disturb traffic
	always @* begin
		nxt_slots = 32'h0000_0000;
		nxt_kbps = speed_of(mc, act_map[mon_port]);
		nxt_rlsd = 1'b0;
		nxt_dsr = 1'b0;
		nxt_lead_cts = 1'b1;
		if (!mc[`CFG_ACTIVE]) begin
			// standby: no slots, carrier and set-ready low, cts high
			nxt_slots = 32'h0000_0000;
			nxt_rlsd = 1'b0;
			nxt_dsr = 1'b0;
			nxt_lead_cts = 1'b1;
		end else if (ldown_ff) begin
			// link down: slots kept, carrier dropped
			nxt_slots = act_map[mon_port];
			nxt_rlsd = 1'b0;
			nxt_dsr = 1'b1;
			nxt_lead_cts = nxt_cts;
		end else begin
			// active: carrier high or following the remote rts
			nxt_slots = act_map[mon_port];
			nxt_rlsd = mc[`CFG_RLSD_RTS] ? rrts_ff : 1'b1;
			nxt_dsr = 1'b1;
			nxt_lead_cts = nxt_cts;
		end
	end

	// registered lead and data-path outputs
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rlsd_ff <= 1'b0;
			dsr_ff <= 1'b0;
			cts_ff <= 1'b1;
			dte_role_ff <= 1'b0;
			wan_slots_ff <= 32'h0000_0000;
			port_kbps_ff <= 11'h000;
		end else begin
			dte_role_ff <= mc[`CFG_DTE];
			wan_slots_ff <= nxt_slots;
			port_kbps_ff <= nxt_kbps;
			rlsd_ff <= nxt_rlsd;
			dsr_ff <= nxt_dsr;
			cts_ff <= nxt_lead_cts;
		end
	end

endmodule

// [testbench/slot_cfg_sva.sv]
// port assertions for the slot configuration block
module slot_cfg_sva(
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// leads and data path
	input wire logic rlsd_ff,
	input wire logic dsr_ff,
	input wire logic cts_ff,
	input wire logic [31:0] wan_slots_ff,
	input wire logic [10:0] port_kbps_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	property p_rdy; psel && !penable |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready missing after setup");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("ready held too long");
	property p_acc; pready |-> psel && penable; endproperty
	a_acc: assert property (p_acc) else $error("ready outside access");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_stby; !dsr_ff |-> wan_slots_ff == 0; endproperty
	a_stby: assert property (p_stby) else $error("standby port holds slots");
	property p_lead; !dsr_ff |-> cts_ff && !rlsd_ff; endproperty
	a_lead: assert property (p_lead) else $error("standby leads wrong");
	property p_kbps; port_kbps_ff == 56 * $countones(wan_slots_ff) || port_kbps_ff == 64 * $countones(wan_slots_ff);
	endproperty
	a_kbps: assert property (p_kbps) else $error("speed not rate times slots");
	property p_ts0; wan_slots_ff[0] == 1'b0; endproperty
	a_ts0: assert property (p_ts0) else $error("slot zero mapped");
	cover property (pslverr);
	cover property (dsr_ff && wan_slots_ff != 0);
	cover property (!dsr_ff && cts_ff);
endmodule
bind slot_cfg slot_cfg_sva u_sva(.clk_sys, .sys_rst, .psel, .penable, .pready, .pslverr, .rlsd_ff, .dsr_ff,
	.cts_ff, .wan_slots_ff, .port_kbps_ff);

// [testbench/far_end_model.sv]
// far end model: dte rts leads and wan framer link status
module far_end_model(
	// clock and commands from the bench
	input wire logic clk_sys,
	input wire logic [2:0] pins,
	// lead and link levels
	output logic link_down,
	output logic local_rts,
	output logic remote_rts
);
	timeunit 1ns;
	timeprecision 1ps;
	// levels change just after an edge
	always @(posedge clk_sys) begin
		{remote_rts, local_rts, link_down} <= pins;
	end
endmodule

// [testbench/serial_port_slot_config_bench.sv]
// self-checking bench for the slot configuration block
`include "slot_cfg_regs.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module serial_port_slot_config_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic rlsd_ff, dsr_ff, cts_ff, dte_role_ff, link_down, local_rts, remote_rts;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, wan_slots_ff, r, m;
	logic [10:0] port_kbps_ff;
	logic [1:0] mon_port = 0;
	logic [2:0] pins = 0;
	logic [32:0] exp_q[$];
	logic [32:0] e_got;
	int n_errors = 0, n_checks = 0, cyc = 0;
	initial forever #10 clk_sys = ~clk_sys;
	slot_cfg dut(.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.mon_port, .link_down, .local_rts, .remote_rts, .rlsd_ff, .dsr_ff, .cts_ff, .dte_role_ff,
		.wan_slots_ff, .port_kbps_ff);
	far_end_model fe(.clk_sys, .pins, .link_down, .local_rts, .remote_rts);
	task complete_run;
		$display("errors %0d checks %0d", n_errors, n_checks);
		if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// one apb transfer, held until ready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		psel <= 0; penable <= 0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d); apb(1, a, d); endtask
	task rd(input logic [11:0] a, input logic [32:0] e); exp_q.push_back(e); apb(0, a, 0); endtask
	task settle(input int n); repeat (n) @(posedge clk_sys); endtask
	// read results against oldest note, plus hang limit
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc > 3000) begin n_errors++; complete_run; end
		if (psel && penable && pready && !pwrite) begin
			e_got = exp_q.pop_front();
			`CHK({pslverr, prdata}, e_got)
		end
	end
	initial begin
		void'($urandom(32'h95be));
		settle(8);
		sys_rst <= 0;
		rd(`OFS_CFG, 0);
		rd(12'h020, 33'h1_0000_0000);
		wr(`OFS_CFG, 32'h5);
		r = $urandom | 32'h0200_0001;
		m = r & 32'h01ff_fffe;
		wr(`OFS_SLOT_MAP, r);
		rd(`OFS_SLOT_MAP, {1'b0, m});
		rd(`OFS_STATUS, 33'h1);
		rd(`OFS_ACT_MAP, 0);
		wr(`OFS_ACTION, 1);
		rd(`OFS_ACT_MAP, {1'b0, m});
		settle(3);
		`CHK(wan_slots_ff, m)
		`CHK(port_kbps_ff, 11'(64 * $countones(m)))
		`CHK({rlsd_ff, dsr_ff}, 2'b11)
		wr(`OFS_CFG, 32'h19);
		wr(`OFS_SLOT_MAP, 32'hffff_ffff);
		rd(`OFS_SLOT_MAP, 33'h0_fffe_fffe);
		wr(`OFS_ACTION, 2);
		rd(`OFS_CFG, 33'h5);
		rd(`OFS_SLOT_MAP, {1'b0, m});
		wr(`OFS_CFG, 32'h9205);
		rd(`OFS_CFG, 33'h1205);
		wr(`OFS_CFG, 32'h3);
		wr(`OFS_ACTION, 4);
		wr(`OFS_PORT_SEL, 1);
		rd(`OFS_CFG, 33'h3);
		rd(`OFS_SLOT_MAP, {1'b0, m});
		wr(`OFS_ACTION, 1);
		mon_port <= 1;
		settle(3);
		`CHK(dte_role_ff, 1'b1)
		`CHK(port_kbps_ff, 11'(56 * $countones(m)))
		pins <= 3'b001;
		settle(8);
		`CHK({rlsd_ff, dsr_ff}, 2'b01)
		mon_port <= 2;
		settle(3);
		`CHK({dsr_ff, cts_ff, wan_slots_ff}, {2'b01, 32'h0})
		complete_run;
	end
endmodule
